// File: hdl/ucs_pkg.sv
// Package: register map, event codes, unit-mask fields for the uncore event counters
package ucs_pkg;

  // ****************************************************************
  // Register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [7:0] UCS_SEL0_OFS = 8'h00;
  localparam logic [7:0] UCS_SEL1_OFS = 8'h04;
  localparam logic [7:0] UCS_CNT0_OFS = 8'h08;
  localparam logic [7:0] UCS_CNT1_OFS = 8'h0c;
  localparam logic [7:0] UCS_CTRL_OFS = 8'h10;

  // ****************************************************************
  // Select register fields
  // ****************************************************************
  localparam int UCS_SEL_EVT_LSB = 0;
  localparam int UCS_SEL_UMASK_LSB = 8;
  localparam int UCS_SEL_UNIT_BIT = 16;
  localparam int UCS_SEL_EN_BIT = 22;
  localparam logic [31:0] UCS_SEL_RST = 32'h0000_0000;
  localparam logic [31:0] UCS_SEL_MASK = 32'h0041_ffff;

  // Select unit: slice box or arbiter
  localparam logic UCS_UNIT_SLICE = 1'b0;
  localparam logic UCS_UNIT_ARB = 1'b1;

  // ****************************************************************
  // Event codes
  // ****************************************************************
  localparam logic [7:0] UCS_EVT_XSNOOP = 8'h22;
  localparam logic [7:0] UCS_EVT_LOOKUP = 8'h34;
  localparam logic [7:0] UCS_EVT_TRK_OCC = 8'h80;
  localparam logic [7:0] UCS_EVT_TRK_REQ = 8'h81;
  localparam logic [7:0] UCS_EVT_COH_OCC = 8'h83;
  localparam logic [7:0] UCS_EVT_COH_REQ = 8'h84;

  // Unit-mask values
  localparam logic [7:0] UCS_UM_ALL = 8'h01;
  localparam logic [7:0] UCS_UM_WRITES = 8'h20;
  localparam logic [7:0] UCS_UM_EVICT = 8'h80;
  localparam int UCS_XSNP_TYPE_W = 5;
  localparam int UCS_XSNP_CAUSE_LSB = 5;
  localparam int UCS_LKP_STATE_W = 4;
  localparam int UCS_LKP_SRC_LSB = 4;

  // Control register bit: write one to clear both counters
  localparam int UCS_CTRL_CLR_BIT = 0;

  // Bus responses
  localparam logic [1:0] UCS_RESP_OKAY = 2'b00;
  localparam logic [1:0] UCS_RESP_SLVERR = 2'b10;

endpackage

// File: hdl/ucs_evt_qual.sv
// Event qualifier: turns select code and unit mask into a per-cycle increment
`timescale 1ns/1ps
module ucs_evt_qual
  import ucs_pkg::*;
#(
  parameter int OCC_W = 6
) (
  // Selection
  input wire logic [7:0] i_evt,
  input wire logic [7:0] i_umask,
  input wire logic i_unit,
  input wire logic i_is_cnt0,
  // Slice box reports (one-cycle pulses)
  input wire logic [4:0] i_xsnp_type,
  input wire logic [2:0] i_xsnp_cause,
  input wire logic [3:0] i_lkp_state,
  input wire logic [3:0] i_lkp_src,
  // Arbiter reports
  input wire logic [OCC_W-1:0] i_trk_occ,
  input wire logic i_trk_req,
  input wire logic i_trk_wr,
  input wire logic i_trk_evict,
  input wire logic [OCC_W-1:0] i_coh_occ,
  input wire logic i_coh_req,
  // Result
  output logic [OCC_W-1:0] o_inc
);

  // ****************************************************************
  // Type-and-filter match: any selected type with any selected cause (snoop), any selected state with any selected source (lookup)
  // ****************************************************************
  logic xsnp_hit;
  logic lkp_hit;
  logic slice_sel;
  logic arb_sel;
  logic [OCC_W-1:0] one;

  assign one = {{(OCC_W-1){1'b0}}, 1'b1};
  assign xsnp_hit = |(i_umask[UCS_XSNP_TYPE_W-1:0] & i_xsnp_type)
    && |(i_umask[7:UCS_XSNP_CAUSE_LSB] & i_xsnp_cause);
  assign lkp_hit = |(i_umask[UCS_LKP_STATE_W-1:0] & i_lkp_state)
    && |(i_umask[7:UCS_LKP_SRC_LSB] & i_lkp_src);
  assign slice_sel = (i_unit == UCS_UNIT_SLICE);
  assign arb_sel = (i_unit == UCS_UNIT_ARB);

  // Increment selection
  always_comb begin
    o_inc = '0;
    if (slice_sel && i_evt == UCS_EVT_XSNOOP && xsnp_hit) begin
      o_inc = one;
    end else if (slice_sel && i_evt == UCS_EVT_LOOKUP && lkp_hit) begin
      o_inc = one;
    end else if (arb_sel && i_evt == UCS_EVT_TRK_OCC && i_is_cnt0
                 && i_umask == UCS_UM_ALL) begin
      o_inc = i_trk_occ;
    end else if (arb_sel && i_evt == UCS_EVT_TRK_REQ) begin
      o_inc = {{(OCC_W-1){1'b0}},
               (i_umask == UCS_UM_ALL && i_trk_req)
               || (i_umask == UCS_UM_WRITES && i_trk_wr)
               || (i_umask == UCS_UM_EVICT && i_trk_evict)};
    end else if (arb_sel && i_evt == UCS_EVT_COH_OCC && i_is_cnt0
                 && i_umask == UCS_UM_ALL) begin
      o_inc = i_coh_occ;
    end else if (arb_sel && i_evt == UCS_EVT_COH_REQ
                 && i_umask == UCS_UM_ALL && i_coh_req) begin
      o_inc = one;
    end
  end

endmodule

// File: hdl/ucs_event_counter.sv
// Top: uncore event selection with two counters behind an AXI4-Lite slave
`timescale 1ns/1ps
module ucs_event_counter
  import ucs_pkg::*;
#(
  parameter int CNT_W = 32,
  parameter int OCC_W = 6
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // AXI4-Lite write address and data
  input wire logic i_awvalid,
  input wire logic [7:0] i_awaddr,
  output logic o_awready,
  input wire logic i_wvalid,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_wready,
  // AXI4-Lite write response
  output logic o_bvalid,
  output logic [1:0] o_bresp,
  input wire logic i_bready,
  // AXI4-Lite read
  input wire logic i_arvalid,
  input wire logic [7:0] i_araddr,
  output logic o_arready,
  output logic o_rvalid,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_rready,
  // Slice box reports
  input wire logic [4:0] i_xsnp_type,
  input wire logic [2:0] i_xsnp_cause,
  input wire logic [3:0] i_lkp_state,
  input wire logic [3:0] i_lkp_src,
  // Arbiter reports
  input wire logic [OCC_W-1:0] i_trk_occ,
  input wire logic i_trk_req,
  input wire logic i_trk_wr,
  input wire logic i_trk_evict,
  input wire logic [OCC_W-1:0] i_coh_occ,
  input wire logic i_coh_req
);

  // ****************************************************************
  // Register decode
  // ****************************************************************
  function automatic logic [2:0] ucs_dec(input logic [7:0] a);
    case (a)
      UCS_SEL0_OFS: ucs_dec = 3'd0;
      UCS_SEL1_OFS: ucs_dec = 3'd1;
      UCS_CNT0_OFS: ucs_dec = 3'd2;
      UCS_CNT1_OFS: ucs_dec = 3'd3;
      UCS_CTRL_OFS: ucs_dec = 3'd4;
      default: ucs_dec = 3'd7;
    endcase
  endfunction

  function automatic logic [31:0] ucs_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] st);
    for (int b = 0; b < 4; b++) begin
      old[b*8 +: 8] = st[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
    ucs_merge = old;
  endfunction

  // ****************************************************************
  // Write channel: capture address and data in either order
  // ****************************************************************
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;
  logic [2:0] wr_idx;
  logic wr_bad;
  logic clr_hit;

  assign wr_go = aw_held_r && w_held_r && !o_bvalid;
  assign wr_idx = ucs_dec(awaddr_r);
  assign wr_bad = (wr_idx == 3'd7);
  assign clr_hit = wr_go && wr_idx == 3'd4 && wstrb_r[0]
    && wdata_r[UCS_CTRL_CLR_BIT];

  // Write handshakes and response
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= UCS_RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= i_wdata;
        wstrb_r <= i_wstrb;
        o_wready <= 1'b0;
      end
      if (wr_go) begin
        o_bvalid <= 1'b1;
        o_bresp <= wr_bad ? UCS_RESP_SLVERR : UCS_RESP_OKAY;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Select registers and counters
  // ****************************************************************
  logic [31:0] sel_r [2];
  logic [CNT_W-1:0] cnt_r [2];
  logic [OCC_W-1:0] inc [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_cnt
      logic sel_wr;
      logic cnt_wr;
      logic [CNT_W-1:0] cnt_nxt;

      assign sel_wr = wr_go && wr_idx == 3'(g);
      assign cnt_wr = wr_go && wr_idx == 3'(g + 2);
      assign cnt_nxt = cnt_r[g] + CNT_W'(inc[g]);

      ucs_evt_qual #(.OCC_W(OCC_W)) u_qual (
        .i_evt(sel_r[g][UCS_SEL_EVT_LSB +: 8]),
        .i_umask(sel_r[g][UCS_SEL_UMASK_LSB +: 8]),
        .i_unit(sel_r[g][UCS_SEL_UNIT_BIT]),
        .i_is_cnt0(g == 0),
        .i_xsnp_type(i_xsnp_type),
        .i_xsnp_cause(i_xsnp_cause),
        .i_lkp_state(i_lkp_state),
        .i_lkp_src(i_lkp_src),
        .i_trk_occ(i_trk_occ),
        .i_trk_req(i_trk_req),
        .i_trk_wr(i_trk_wr),
        .i_trk_evict(i_trk_evict),
        .i_coh_occ(i_coh_occ),
        .i_coh_req(i_coh_req),
        .o_inc(inc[g])
      );

      // Select register, masked to defined bits
      always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          sel_r[g] <= UCS_SEL_RST;
        end else if (sel_wr) begin
          sel_r[g] <= ucs_merge(sel_r[g], wdata_r, wstrb_r)
                      & UCS_SEL_MASK;
        end
      end

      // Counter: clock only, reset to zero, software clear or preload
      always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          cnt_r[g] <= '0;
        end else if (clr_hit) begin
          cnt_r[g] <= '0;
        end else if (cnt_wr) begin
          cnt_r[g] <= CNT_W'(ucs_merge(32'(cnt_r[g]), wdata_r, wstrb_r));
        end else if (sel_r[g][UCS_SEL_EN_BIT]) begin
          cnt_r[g] <= cnt_nxt;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Read channel: one-cycle answer after the address is taken
  // ****************************************************************
  logic [2:0] rd_idx;
  logic [31:0] rd_val;

  assign rd_idx = ucs_dec(i_araddr);
  assign rd_val = (rd_idx == 3'd0) ? sel_r[0] :
                  (rd_idx == 3'd1) ? sel_r[1] :
                  (rd_idx == 3'd2) ? 32'(cnt_r[0]) :
                  (rd_idx == 3'd3) ? 32'(cnt_r[1]) : 32'h0000_0000;

  // Read handshake
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= UCS_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= rd_val;
      o_rresp <= (rd_idx == 3'd7) ? UCS_RESP_SLVERR : UCS_RESP_OKAY;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

endmodule

// File: tb/ucs_event_counter_sva.sv
// Checker: bus handshake and reset properties of the event counter top
`timescale 1ns/1ps
module ucs_event_counter_sva
  import ucs_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Register bus
  input wire logic i_awvalid, o_awready, i_wvalid, o_wready,
  input wire logic o_bvalid, i_bready, i_arvalid, o_arready,
  input wire logic o_rvalid, i_rready,
  input wire logic [1:0] o_bresp, o_rresp,
  input wire logic [31:0] o_rdata
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_RST_IDLE: assert property ($rose(i_rstn) |->
    o_awready && o_wready && o_arready && !o_bvalid && !o_rvalid)
    else $error("bus not idle after reset");
  AST_B_AFTER_WR: assert property (i_awvalid && o_awready &&
    i_wvalid && o_wready |-> ##2 o_bvalid)
    else $error("no write response");
  AST_B_DONE: assert property (o_bvalid && i_bready |=>
    !o_bvalid && o_awready && o_wready) else $error("write not retired");
  AST_W_BLOCK: assert property (o_bvalid |->
    !o_awready && !o_wready) else $error("write taken while busy");
  AST_R_AFTER_AR: assert property (i_arvalid && o_arready |=>
    o_rvalid) else $error("no read data");
  AST_R_DONE: assert property (o_rvalid && i_rready |=>
    !o_rvalid && o_arready) else $error("read not retired");
  AST_AR_BLOCK: assert property (o_rvalid |-> !o_arready)
    else $error("read taken while busy");
  AST_BRESP_CODE: assert property (o_bvalid |->
    o_bresp == UCS_RESP_OKAY || o_bresp == UCS_RESP_SLVERR)
    else $error("bad write response code");
  AST_RRESP_CODE: assert property (o_rvalid |->
    o_rresp == UCS_RESP_OKAY || o_rresp == UCS_RESP_SLVERR)
    else $error("bad read response code");
  // Main scenarios
  COV_WR: cover property (o_bvalid && i_bready);
  COV_ERR: cover property (o_bvalid && o_bresp == UCS_RESP_SLVERR);
  COV_RD: cover property (o_rvalid && i_rready && o_rdata != 32'h0);
endmodule

// File: tb/ucs_event_counter_tb_top.sv
// Testbench: drives bus and event reports, checks counter values
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  fail_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
  $time, g, e); end end
module ucs_event_counter_tb_top;
  import ucs_pkg::*;
  // ****************************************************************
  // Stimulus and design
  // ****************************************************************
  logic i_core_clk = 1'b0, i_rstn = 1'b0;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic i_arvalid = 1'b0, i_rready = 1'b0;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0, ev = 32'h0, rd_q;
  logic [3:0] i_wstrb = 4'hf;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp, rr_q;
  logic [31:0] o_rdata;
  int fail_count = 0, check_count = 0;
  always #5 i_core_clk = ~i_core_clk;
  ucs_event_counter u_ucs_event_counter (.i_core_clk(i_core_clk),
    .i_rstn(i_rstn), .i_awvalid(i_awvalid), .i_awaddr(i_awaddr),
    .o_awready(o_awready), .i_wvalid(i_wvalid), .i_wdata(i_wdata),
    .i_wstrb(i_wstrb), .o_wready(o_wready), .o_bvalid(o_bvalid),
    .o_bresp(o_bresp), .i_bready(i_bready), .i_arvalid(i_arvalid),
    .i_araddr(i_araddr), .o_arready(o_arready), .o_rvalid(o_rvalid),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .i_rready(i_rready),
    .i_xsnp_type(ev[4:0]), .i_xsnp_cause(ev[7:5]),
    .i_lkp_state(ev[11:8]), .i_lkp_src(ev[15:12]),
    .i_trk_occ(ev[21:16]), .i_trk_req(ev[22]), .i_trk_wr(ev[23]),
    .i_trk_evict(ev[24]), .i_coh_occ(ev[30:25]), .i_coh_req(ev[31]));
  // Bus write: address and data offered together, response awaited
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge i_core_clk);
    i_awvalid <= 1'b1;
    i_awaddr <= a;
    i_wvalid <= 1'b1;
    i_wdata <= d;
    i_bready <= 1'b1;
    do begin
      @(posedge i_core_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
    end while (!o_bvalid);
    r = o_bresp;
    i_bready <= 1'b0;
  endtask
  // Bus read
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    i_rready <= 1'b1;
    do begin
      @(posedge i_core_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
    end while (!o_rvalid);
    d = o_rdata;
    rr_q = o_rresp;
    i_rready <= 1'b0;
  endtask
  // Select word: enable, unit, unit mask, event code
  function automatic logic [31:0] sv(logic u, logic [7:0] m, e);
    return {9'h0, 1'b1, 5'h0, u, m, e};
  endfunction
  // Select word for an arbiter event
  function automatic logic [31:0] arb(logic [7:0] m, e);
    return sv(1'b1, m, e);
  endfunction
  // Program a counter, clear, hold reports n cycles, read back
  task automatic run(input int c, input logic [31:0] s, evv,
                     input int n, input logic [31:0] exp);
    logic [1:0] r;
    wr(c ? UCS_SEL1_OFS : UCS_SEL0_OFS, s, r);
    `CHK(r, UCS_RESP_OKAY)
    wr(UCS_CTRL_OFS, 32'h1, r);
    @(posedge i_core_clk);
    ev <= evv;
    repeat (n) @(posedge i_core_clk);
    ev <= 32'h0;
    rd(c ? UCS_CNT1_OFS : UCS_CNT0_OFS, rd_q);
    `CHK(rd_q, exp)
  endtask
  task automatic t_reg;
    logic [1:0] r;
    rd(UCS_SEL0_OFS, rd_q);
    `CHK(rd_q, 32'h0)
    `CHK(rr_q, UCS_RESP_OKAY)
    wr(8'h14, 32'h1, r);
    `CHK(r, UCS_RESP_SLVERR)
    rd(8'h14, rd_q);
    `CHK(rd_q, 32'h0)
    `CHK(rr_q, UCS_RESP_SLVERR)
    run(1, sv(1'b1, 8'h21, UCS_EVT_XSNOOP), 32'h21, 3, 32'h0);
    run(0, arb(8'h01, UCS_EVT_COH_REQ), 32'h1 << 31, 2, 32'd2);
    @(posedge i_core_clk);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    rd(UCS_CNT0_OFS, rd_q);
    `CHK(rd_q, 32'h0)
    $display("test t_reg done");
  endtask
  task automatic t_slice;
    logic [31:0] s;
    logic [31:0] e;
    for (int i = 0; i < 5; i++) begin
      for (int j = 0; j < 3; j++) begin
        s = sv(1'b0, 8'(1 << i) | 8'(8'h20 << j), UCS_EVT_XSNOOP);
        e = 32'(1 << i) | 32'(1 << (5 + j));
        run(0, s, e, 2 + i, 32'(2 + i));
        e = 32'(1 << ((i + 1) % 5)) | 32'(1 << (5 + j));
        run(1, s, e, 3, 32'h0);
      end
    end
    run(0, sv(1'b0, 8'hff, UCS_EVT_XSNOOP), 32'h3f, 4, 32'd4);
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 4; j++) begin
        s = sv(1'b0, 8'(1 << i) | 8'(8'h10 << j), UCS_EVT_LOOKUP);
        e = 32'(1 << (8 + i)) | 32'(1 << (12 + j));
        run(0, s, e, 1 + j, 32'(1 + j));
        e = 32'(1 << (8 + (i + 1) % 4)) | 32'(1 << (12 + j));
        run(1, s, e, 2, 32'h0);
      end
    end
    $display("test t_slice done");
  endtask
  task automatic t_arb;
    run(0, arb(8'h01, UCS_EVT_TRK_OCC), 32'd5 << 16, 4, 32'd20);
    run(1, arb(8'h01, UCS_EVT_TRK_OCC), 32'd5 << 16, 4, 32'd0);
    run(0, arb(8'h01, UCS_EVT_TRK_REQ), 32'h1 << 22, 3, 32'd3);
    run(1, arb(8'h20, UCS_EVT_TRK_REQ), 32'h1 << 23, 3, 32'd3);
    run(1, arb(8'h80, UCS_EVT_TRK_REQ), 32'h1 << 24, 3, 32'd3);
    run(1, arb(8'h80, UCS_EVT_TRK_REQ), 32'h1 << 23, 3, 32'd0);
    run(0, arb(8'h01, UCS_EVT_COH_OCC), 32'd7 << 25, 4, 32'd28);
    run(1, arb(8'h01, UCS_EVT_COH_OCC), 32'd7 << 25, 4, 32'd0);
    run(1, arb(8'h01, UCS_EVT_COH_REQ), 32'h1 << 31, 5, 32'd5);
    $display("test t_arb done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge i_core_clk);
    fail_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    t_reg();
    t_slice();
    t_arb();
    finish_test();
  end
endmodule
bind ucs_event_counter ucs_event_counter_sva u_ucs_event_counter_sva (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_awvalid(i_awvalid),
  .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
  .o_bvalid(o_bvalid), .i_bready(i_bready), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rvalid(o_rvalid), .i_rready(i_rready),
  .o_bresp(o_bresp), .o_rresp(o_rresp), .o_rdata(o_rdata));
